// ### verilog/tss_pkg.sv
// Shared constants and types for the trigger source select block
package tss_pkg;
    localparam int ADC_W      = 12;
    localparam int MAG_W      = 16;
    localparam int DWELL_W    = 16;
    localparam int LOG_W      = 8;
    // Hysteresis around the raw sample threshold, in converter counts
    localparam logic [ADC_W-1:0] ADC_HYST = 12'h014;
    localparam logic [DWELL_W-1:0] DWELL_RST = 16'h0001;

    typedef enum logic [2:0] {
        RAW_SAMPLE_SOURCE     = 3'h0,
        LOG_MAGNITUDE_SOURCE  = 3'h1,
        EXTERNAL_ECL_SOURCE   = 3'h2,
        EXTERNAL_TTL_SOURCE   = 3'h3,
        MANUAL_LINE_SOURCE    = 3'h4,
        INSTANT_SOURCE        = 3'h5
    } tss_source_t;
    // Legacy selection shares the ECL code
    localparam tss_source_t LEGACY_EXTERNAL_SOURCE = EXTERNAL_ECL_SOURCE;

    typedef enum logic {
        RISING_EDGE_SELECT  = 1'b0,
        FALLING_EDGE_SELECT = 1'b1
    } tss_slope_t;

    typedef enum logic [1:0] {
        TSS_IDLE  = 2'h0,
        TSS_ARMED = 2'h1,
        TSS_FIRED = 2'h2
    } tss_state_t;
endpackage

// ### verilog/tss_log2.sv
// Registered log2 approximation of the magnitude (integer part plus mantissa bits)
`timescale 1ns/1ns
module tss_log2
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Linear magnitude in, log out one cycle later
    input  wire logic [tss_pkg::MAG_W-1:0] mag_in,
    input  wire logic                       mag_valid,
    output logic      [tss_pkg::LOG_W-1:0] log_out,
    output logic                            log_valid
);
    logic [tss_pkg::LOG_W-1:0] log_d;
    logic [tss_pkg::LOG_W-1:0] log_q;
    logic                      vld_q;
    logic [3:0]                msb;
    logic [tss_pkg::MAG_W-1:0] norm;

    always_comb
    begin
        msb = 4'h0;
        for (int i = 0; i < tss_pkg::MAG_W; i++)
        begin
            if (mag_in[i])
                msb = 4'(i);
        end
        norm  = mag_in << (4'hf - msb);
        // Four mantissa bits give about 0.4 dB steps, enough for a threshold
        log_d = {msb, norm[14:11]};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            log_q <= 8'h00;
            vld_q <= 1'b0;
        end
        else
        begin
            log_q <= log_d;
            vld_q <= mag_valid;
        end
    end

    assign log_out   = log_q;
    assign log_valid = vld_q;
endmodule // tss_log2

// ### verilog/tss_dwell.sv
// Counts consecutive low samples before declaring the magnitude low
`timescale 1ns/1ns
module tss_dwell
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Sample stream
    input  wire logic                         clear,
    input  wire logic                         sample_valid,
    input  wire logic                         below,
    input  wire logic [tss_pkg::DWELL_W-1:0] dwell,
    output logic                              low_seen
);
    logic [tss_pkg::DWELL_W-1:0] cnt_d;
    logic [tss_pkg::DWELL_W-1:0] cnt_q;
    logic                        low_d;
    logic                        low_q;

    always_comb
    begin
        cnt_d = cnt_q;
        low_d = low_q;
        if (clear)
        begin
            cnt_d = 16'h0000;
            low_d = 1'b0;
        end
        else if (sample_valid)
        begin
            if (below)
            begin
                if (cnt_q != 16'hffff)
                    cnt_d = cnt_q + 16'h0001;
                if (cnt_q + 16'h0001 >= dwell)
                    low_d = 1'b1;
            end
            else
                cnt_d = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 16'h0000;
            low_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            low_q <= low_d;
        end
    end

    assign low_seen = low_q;
endmodule // tss_dwell

// ### verilog/tss_top.sv
// Trigger source selection, slope and threshold logic driving the shared sync line
`timescale 1ns/1ns
module tss_top
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Configuration
    input  wire logic [2:0]                   source_select,
    input  wire logic                         slope,
    input  wire logic                         generation_enable,
    input  wire logic [tss_pkg::ADC_W-1:0]   adc_level,
    input  wire logic [tss_pkg::LOG_W-1:0]   mag_level,
    input  wire logic [tss_pkg::DWELL_W-1:0] mag_dwell,
    // Sample streams
    input  wire logic [tss_pkg::ADC_W-1:0]   adc_sample,
    input  wire logic                         adc_valid,
    input  wire logic [tss_pkg::MAG_W-1:0]   filt_mag,
    input  wire logic                         filt_valid,
    // Front-panel external trigger, ECL and TTL receivers
    input  wire logic                         ext_ecl_in,
    input  wire logic                         ext_ttl_in,
    // Measurement state machine
    input  wire logic                         trig_state,
    // Shared open-collector sync line
    input  wire logic                         sync_in_n,
    output logic                              sync_out_n,
    output logic                              sync_oe,
    // Status
    output logic                              meas_start,
    output logic                              own_trigger
);
    tss_pkg::tss_state_t  st_d;
    tss_pkg::tss_state_t  st_q;
    tss_pkg::tss_source_t src_d;
    tss_pkg::tss_source_t src_q;
    logic                 slope_d;
    logic                 slope_q;
    logic                 adc_hi_d;
    logic                 adc_hi_q;
    logic                 adc_ev;
    logic                 ext_d;
    logic                 ext_q;
    logic                 ext_ev;
    logic                 first_d;
    logic                 first_q;
    logic                 drive_d;
    logic                 drive_q;
    logic                 start_d;
    logic                 start_q;
    logic                 own_d;
    logic                 own_q;
    logic                 mag_ev;
    logic                 fire;
    logic                 ext_now;
    logic                 line_pulled;
    logic [tss_pkg::LOG_W-1:0] log_mag;
    logic                      log_valid;
    logic                      below;
    logic                      low_seen;
    logic signed [tss_pkg::ADC_W:0] smp;
    logic signed [tss_pkg::ADC_W:0] lvl;
    logic signed [tss_pkg::ADC_W:0] hyst;

    // Our own pull shows here too; the fired state keeps it from re-triggering
    assign line_pulled = !sync_in_n;

    tss_log2 u_log
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .mag_in    (filt_mag),
        .mag_valid (filt_valid),
        .log_out   (log_mag),
        .log_valid (log_valid)
    );

    assign below = log_mag < mag_level;

    tss_dwell u_dwell
    (
        .clk          (clk),
        .rst_n        (rst_n),
        .clear        (st_q != tss_pkg::TSS_ARMED),
        .sample_valid (log_valid),
        .below        (below),
        .dwell        (mag_dwell),
        .low_seen     (low_seen)
    );

    // Crossing from a dwelled low to above the threshold
    assign mag_ev = log_valid && low_seen && !below;

    // Raw sample comparator with hysteresis band
    always_comb
    begin
        smp  = {adc_sample[tss_pkg::ADC_W-1], adc_sample};
        lvl  = {adc_level[tss_pkg::ADC_W-1], adc_level};
        hyst = {1'b0, tss_pkg::ADC_HYST};
        adc_hi_d = adc_hi_q;
        if (adc_valid)
        begin
            if (smp > lvl + hyst)
                adc_hi_d = 1'b1;
            else if (smp < lvl - hyst)
                adc_hi_d = 1'b0;
        end
        // Seed history on arming so a standing level is not an edge
        if (first_q)
            adc_ev = 1'b0;
        else
            adc_ev = (adc_hi_d != adc_hi_q) &&
                     (adc_hi_d == (slope_q == tss_pkg::RISING_EDGE_SELECT));
    end

    // External input chosen by receiver level standard
    always_comb
    begin
        ext_now = (src_q == tss_pkg::EXTERNAL_TTL_SOURCE) ? ext_ttl_in : ext_ecl_in;
        ext_d   = ext_now;
        if (first_q)
            ext_ev = 1'b0;
        else
            ext_ev = (ext_now != ext_q) &&
                     (ext_now == (slope_q == tss_pkg::RISING_EDGE_SELECT));
    end

    always_comb
    begin
        case (src_q)
            tss_pkg::RAW_SAMPLE_SOURCE:    fire = adc_ev;
            tss_pkg::LOG_MAGNITUDE_SOURCE: fire = mag_ev;
            tss_pkg::EXTERNAL_ECL_SOURCE,
            tss_pkg::EXTERNAL_TTL_SOURCE:  fire = ext_ev;
            tss_pkg::MANUAL_LINE_SOURCE:   fire = 1'b0;
            tss_pkg::INSTANT_SOURCE:       fire = 1'b1;
            default:                       fire = 1'b0;
        endcase
    end

    // Trigger sequencer
    always_comb
    begin
        st_d    = st_q;
        src_d   = src_q;
        slope_d = slope_q;
        first_d = 1'b0;
        drive_d = 1'b0;
        start_d = 1'b0;
        own_d   = 1'b0;
        case (st_q)
            tss_pkg::TSS_IDLE:
            begin
                if (trig_state)
                begin
                    // Latch source and slope only on entry
                    src_d   = tss_pkg::tss_source_t'(source_select);
                    slope_d = slope;
                    first_d = 1'b1;
                    st_d    = tss_pkg::TSS_ARMED;
                end
            end
            tss_pkg::TSS_ARMED:
            begin
                if (!trig_state)
                    st_d = tss_pkg::TSS_IDLE;
                else if (line_pulled)
                begin
                    start_d = 1'b1;
                    st_d    = tss_pkg::TSS_FIRED;
                end
                else if (fire && generation_enable)
                begin
                    drive_d = 1'b1;
                    start_d = 1'b1;
                    own_d   = 1'b1;
                    st_d    = tss_pkg::TSS_FIRED;
                end
            end
            tss_pkg::TSS_FIRED:
            begin
                // Hold the line until the measurement leaves trigger state
                drive_d = drive_q && trig_state;
                if (!trig_state)
                    st_d = tss_pkg::TSS_IDLE;
            end
            default:
                st_d = tss_pkg::TSS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q     <= tss_pkg::TSS_IDLE;
            src_q    <= tss_pkg::RAW_SAMPLE_SOURCE;
            slope_q  <= tss_pkg::RISING_EDGE_SELECT;
            adc_hi_q <= 1'b0;
            ext_q    <= 1'b0;
            first_q  <= 1'b0;
            drive_q  <= 1'b0;
            start_q  <= 1'b0;
            own_q    <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            src_q    <= src_d;
            slope_q  <= slope_d;
            adc_hi_q <= adc_hi_d;
            ext_q    <= ext_d;
            first_q  <= first_d;
            drive_q  <= drive_d;
            start_q  <= start_d;
            own_q    <= own_d;
        end
    end

    // Open collector: only the enable moves, the level is always low
    assign sync_out_n  = 1'b0;
    assign sync_oe     = drive_q;
    assign meas_start  = start_q;
    assign own_trigger = own_q;

    drive_needs_armed_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(drive_q) |-> $past(st_q) == tss_pkg::TSS_ARMED && $past(sync_in_n))
        else $error("sync driven outside armed state or with line pulled");
    gen_disable_a: assert property (@(posedge clk) disable iff (!rst_n)
        !generation_enable |=> !$rose(own_q))
        else $error("own trigger while generation disabled");
    manual_no_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
        own_q |-> $past(src_q) != tss_pkg::MANUAL_LINE_SOURCE)
        else $error("manual source generated a trigger");
    instant_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == tss_pkg::TSS_ARMED && src_q == tss_pkg::INSTANT_SOURCE && trig_state
         && sync_in_n && generation_enable) |=> own_q && meas_start)
        else $error("instant source did not fire at once");
    follow_line_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == tss_pkg::TSS_ARMED && trig_state && !sync_in_n) |=> meas_start)
        else $error("pulled sync line did not start measurement");
    mag_low_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (own_q && src_q == tss_pkg::LOG_MAGNITUDE_SOURCE) |-> $past(low_seen))
        else $error("magnitude trigger without dwelled low");
    src_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q != tss_pkg::TSS_IDLE |=> $stable(src_q))
        else $error("source changed while armed");
    adc_hyst_a: assert property (@(posedge clk) disable iff (!rst_n)
        (own_q && src_q == tss_pkg::RAW_SAMPLE_SOURCE
         && slope_q == tss_pkg::RISING_EDGE_SELECT) |-> adc_hi_q)
        else $error("rising raw trigger without high state");
    start_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        meas_start |=> !meas_start)
        else $error("measurement start longer than one cycle");

    // Quiet sources, start only in the fired state, the held line and edge direction
    trig_low_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !trig_state |=> !meas_start)
        else $error("measurement started outside trigger state");
    start_fired_a: assert property (@(posedge clk) disable iff (!rst_n)
        meas_start |-> st_q == tss_pkg::TSS_FIRED)
        else $error("measurement start without leaving armed state");
    own_drives_line_a: assert property (@(posedge clk) disable iff (!rst_n)
        own_trigger |-> sync_oe)
        else $error("own trigger without pulling the sync line");
    line_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_oe && trig_state) |=> sync_oe)
        else $error("sync line released while trigger state lasts");
    manual_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == tss_pkg::TSS_ARMED && src_q == tss_pkg::MANUAL_LINE_SOURCE && sync_in_n)
        |=> !meas_start)
        else $error("manual source started without a line pull");
    unknown_code_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == tss_pkg::TSS_ARMED && src_q > tss_pkg::INSTANT_SOURCE && sync_in_n)
        |=> !meas_start)
        else $error("unused source code started a measurement");
    ext_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        (own_q && slope_q == tss_pkg::RISING_EDGE_SELECT
         && (src_q == tss_pkg::EXTERNAL_ECL_SOURCE || src_q == tss_pkg::EXTERNAL_TTL_SOURCE))
        |-> ext_q)
        else $error("rising external trigger without high input");
    adc_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        (own_q && src_q == tss_pkg::RAW_SAMPLE_SOURCE
         && slope_q == tss_pkg::FALLING_EDGE_SELECT) |-> !adc_hi_q)
        else $error("falling raw trigger without low state");
endmodule // tss_top

// ### test/tss_peer.sv
// Model of another digitizer module sharing the open-collector sync line
`timescale 1ns/1ns
module tss_peer
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench command and the reported trigger state
    input  wire logic pull_cmd,
    input  wire logic trig_seen,
    // Open-collector drive, high while pulling
    output logic      pull_oe
);
    logic pull_d;
    logic pull_q;

    // Same source type assumed on every module of the line
    always_comb
    begin
        // Pull only once the trigger state is reported
        pull_d = pull_cmd && trig_seen;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pull_q <= 1'b0;
        else
            pull_q <= pull_d;
    end

    assign pull_oe = pull_q;
endmodule // tss_peer

// ### test/trigger_source_select_tb.sv
// Self-checking bench for the trigger source select block
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("Error %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module trigger_source_select_tb;
    typedef struct packed {
        logic [2:0]  src;
        logic        slp;
        logic        gen;
        logic [11:0] a0;
        logic [11:0] a1;
        logic [15:0] m0;
        logic [15:0] m1;
        logic [15:0] dw;
        logic [1:0]  x0;
        logic [1:0]  x1;
        logic        f;
    } tss_row_t;

    logic        clk;
    logic        rst_n;
    logic [2:0]  source_select;
    logic        slope;
    logic        generation_enable;
    logic [11:0] adc_level;
    logic [7:0]  mag_level;
    logic [15:0] mag_dwell;
    logic [11:0] adc_sample;
    logic        adc_valid;
    logic [15:0] filt_mag;
    logic        filt_valid;
    logic        ext_ecl_in;
    logic        ext_ttl_in;
    logic        trig_state;
    logic        sync_out_n;
    logic        sync_oe;
    logic        meas_start;
    logic        own_trigger;
    logic        pull_cmd;
    logic        peer_oe;
    logic        sync_line_n;
    logic [7:0]  n_start = 8'h00;
    logic [7:0]  n_own = 8'h00;
    int          failures = 0;
    int          n_tests = 0;
    tss_row_t    rows [17];

    // Released line floats high through the backplane pull-up
    assign sync_line_n = (sync_oe ? sync_out_n : 1'b1) & ~peer_oe;

    tss_top uut (.clk(clk), .rst_n(rst_n), .source_select(source_select), .slope(slope),
        .generation_enable(generation_enable), .adc_level(adc_level), .mag_level(mag_level),
        .mag_dwell(mag_dwell), .adc_sample(adc_sample), .adc_valid(adc_valid),
        .filt_mag(filt_mag), .filt_valid(filt_valid), .ext_ecl_in(ext_ecl_in),
        .ext_ttl_in(ext_ttl_in), .trig_state(trig_state), .sync_in_n(sync_line_n),
        .sync_out_n(sync_out_n), .sync_oe(sync_oe), .meas_start(meas_start),
        .own_trigger(own_trigger));

    tss_peer peer (.clk(clk), .rst_n(rst_n), .pull_cmd(pull_cmd), .trig_seen(trig_state),
        .pull_oe(peer_oe));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (meas_start === 1'b1) n_start++;
        if (own_trigger === 1'b1) n_own++;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic drop_state();
        @(posedge clk);
        trig_state <= 1'b0;
        pull_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK("sync_oe released", 1'b0, sync_oe)
    endtask

    task automatic run_case(input tss_row_t r);
        logic [7:0] s0;
        logic [7:0] o0;
        @(posedge clk);
        source_select <= r.src;
        slope <= r.slp;
        generation_enable <= r.gen;
        mag_dwell <= r.dw;
        adc_sample <= r.a0;
        filt_mag <= r.m0;
        {ext_ecl_in, ext_ttl_in} <= r.x0;
        repeat (2) @(posedge clk);
        #1 s0 = n_start;
        o0 = n_own;
        @(posedge clk);
        trig_state <= 1'b1;
        repeat (8) @(posedge clk);
        adc_sample <= r.a1;
        filt_mag <= r.m1;
        {ext_ecl_in, ext_ttl_in} <= r.x1;
        repeat (12) @(posedge clk);
        #1 `CHK("meas_start count", {7'h00, r.f}, n_start - s0)
        `CHK("own_trigger count", {7'h00, r.f}, n_own - o0)
        `CHK("sync_oe held", r.f, sync_oe)
        drop_state();
    endtask

    // Another module pulls the line while this one is armed
    task automatic peer_case(input logic [2:0] src, input logic gen);
        logic [7:0] s0;
        logic [7:0] o0;
        @(posedge clk);
        source_select <= src;
        generation_enable <= gen;
        adc_sample <= 12'hf9c;
        repeat (2) @(posedge clk);
        #1 s0 = n_start;
        o0 = n_own;
        @(posedge clk);
        trig_state <= 1'b1;
        repeat (4) @(posedge clk);
        adc_sample <= 12'h064;
        pull_cmd <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK("followed start", 8'h01, n_start - s0)
        `CHK("own count", 8'h00, n_own - o0)
        `CHK("sync_oe idle", 1'b0, sync_oe)
        drop_state();
    endtask

    initial
    begin
        logic [7:0] s0;
        rst_n = 1'b0;
        source_select = 3'h0;
        slope = 1'b0;
        generation_enable = 1'b1;
        adc_level = 12'h000;
        mag_level = 8'h80;
        mag_dwell = 16'h0001;
        adc_sample = 12'h000;
        adc_valid = 1'b1;
        filt_mag = 16'h0010;
        filt_valid = 1'b1;
        ext_ecl_in = 1'b0;
        ext_ttl_in = 1'b0;
        trig_state = 1'b0;
        pull_cmd = 1'b0;
        rows = '{
            '{3'h0, 1'b0, 1'b1, 12'hf9c, 12'h064, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h0, 1'b1},
            '{3'h0, 1'b1, 1'b1, 12'h064, 12'hf9c, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h0, 1'b1},
            '{3'h0, 1'b0, 1'b1, 12'hf9c, 12'h00a, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h0, 1'b0},
            '{3'h0, 1'b0, 1'b0, 12'hf9c, 12'h064, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h0, 1'b0},
            '{3'h1, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h1000, 16'h0004, 2'h0, 2'h0, 1'b1},
            '{3'h1, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h00c8, 16'h0001, 2'h0, 2'h0, 1'b0},
            '{3'h1, 1'b0, 1'b1, 12'h000, 12'h000, 16'h1000, 16'h1000, 16'h0001, 2'h0, 2'h0, 1'b0},
            '{3'h1, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h1000, 16'h0020, 2'h0, 2'h0, 1'b0},
            '{3'h2, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h2, 1'b1},
            '{3'h2, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h1, 1'b0},
            '{3'h2, 1'b1, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h0010, 16'h0001, 2'h3, 2'h1, 1'b1},
            '{3'h3, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h1, 1'b1},
            '{3'h3, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h2, 1'b0},
            '{tss_pkg::LEGACY_EXTERNAL_SOURCE, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010,
              16'h0010, 16'h0001, 2'h0, 2'h2, 1'b1},
            '{3'h4, 1'b0, 1'b1, 12'hf9c, 12'h064, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h3, 1'b0},
            '{3'h5, 1'b0, 1'b1, 12'h000, 12'h000, 16'h0010, 16'h0010, 16'h0001, 2'h0, 2'h0, 1'b1},
            '{3'h7, 1'b0, 1'b1, 12'hf9c, 12'h064, 16'h0010, 16'h1000, 16'h0001, 2'h0, 2'h3, 1'b0}};
        repeat (12) @(posedge clk);
        #1 `CHK("reset sync_oe", 1'b0, sync_oe)
        `CHK("reset meas_start", 1'b0, meas_start)
        `CHK("reset sync_out_n", 1'b0, sync_out_n)
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Rows: raw, hysteresis, log compare, dwell, ECL, TTL, legacy, manual, instant
        for (int i = 0; i < 17; i++)
        begin
            run_case(rows[i]);
            $display("case %0d done", i);
        end
        // Instant latency: outputs one edge after the entry edge
        @(posedge clk);
        source_select <= 3'h5;
        generation_enable <= 1'b1;
        @(posedge clk);
        trig_state <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK("instant start", 1'b1, meas_start)
        @(posedge clk);
        #1 `CHK("start pulse width", 1'b0, meas_start)
        `CHK("line pulled", 1'b1, sync_oe)
        drop_state();
        $display("instant latency done");
        peer_case(3'h4, 1'b1);
        peer_case(3'h0, 1'b0);
        $display("sync follow done");
        // Mid-state source change waits for the next entry
        @(posedge clk);
        source_select <= 3'h4;
        generation_enable <= 1'b1;
        repeat (2) @(posedge clk);
        #1 s0 = n_start;
        @(posedge clk);
        trig_state <= 1'b1;
        repeat (4) @(posedge clk);
        source_select <= 3'h5;
        repeat (6) @(posedge clk);
        #1 `CHK("no start after change", 8'h00, n_start - s0)
        drop_state();
        @(posedge clk);
        trig_state <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK("start at next entry", 8'h01, n_start - s0)
        drop_state();
        $display("source change done");
        complete_run();
    end

    initial
    begin
        #1000000;
        failures++;
        complete_run();
    end
endmodule // trigger_source_select_tb
